//--- radio_ctrl_pkg.sv
// shared constants and types of the auto-retry transmit controller
package radio_ctrl_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_HZ           = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS    = 1_000_000_000 / CLK_HZ;
  localparam int unsigned SYMBOL_NS        = 16_000;
  localparam int unsigned ACK_WAIT_SYM     = 46;
  localparam int unsigned ACK_WAIT_STD_SYM = 54;
  localparam int unsigned ACK_WAIT_CYC     = ACK_WAIT_SYM * SYMBOL_NS / CLK_PERIOD_NS;
  localparam int unsigned IRQ_LATE_SYM     = 2;
  localparam int unsigned IRQ_LATE_CYC     = IRQ_LATE_SYM * SYMBOL_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // register map and fields
  localparam logic [5:0] ADDR_STATE   = 6'h01;
  localparam logic [5:0] ADDR_CMD     = 6'h02;
  localparam logic [5:0] ADDR_CCA     = 6'h08;
  localparam logic [5:0] ADDR_VERSION = 6'h1d;
  localparam logic [5:0] ADDR_RETRY   = 6'h2c;
  localparam int unsigned SPI_WR_BIT  = 7;
  localparam int unsigned RESULT_LSB  = 5;
  localparam int unsigned RETRY_LSB   = 4;
  localparam int unsigned CCA_REQ_BIT = 7;
  localparam int unsigned CHANNEL_CHECK_DONE_BIT = 7;
  localparam logic [3:0] RETRY_RST    = 4'h3;
  localparam logic [7:0] VERSION_RST  = 8'h5a;  // arbitrary value

  typedef enum logic [4:0] {
    CMD_NOP      = 5'h00,
    CMD_TX_START = 5'h02,
    CMD_RX       = 5'h06,
    CMD_OFF      = 5'h08,
    CMD_SYNTH    = 5'h09,
    CMD_ARET     = 5'h19
  } transceiver_command_t;

  typedef enum logic [2:0] {
    RES_SUCCESS = 3'h0,
    RES_NO_ACK  = 3'h5
  } transaction_result_t;

  typedef enum logic [2:0] {
    S_OFF       = 3'b000,
    S_RX        = 3'b001,
    S_SYNTH     = 3'b010,
    S_ARET_IDLE = 3'b011,
    S_TX        = 3'b100,
    S_ACK       = 3'b101,
    S_ACK_RX    = 3'b110
  } ctrl_state_t;

  // visible transceiver_state codes
  localparam logic [4:0] VIS_OFF    = 5'h08;
  localparam logic [4:0] VIS_RX     = 5'h06;
  localparam logic [4:0] VIS_SYNTH  = 5'h09;
  localparam logic [4:0] VIS_IDLE   = 5'h19;
  localparam logic [4:0] VIS_ACTIVE = 5'h12;

  typedef struct packed {
    logic       stb;
    logic [5:0] addr;
    logic [7:0] data;
  } reg_wr_t;

  typedef struct packed {
    logic tx_done;
    logic preamble;
    logic rx_done;
    logic fcs_ok;
    logic is_ack;
    logic cca_valid;
    logic cca_busy;
  } radio_evt_t;

endpackage : radio_ctrl_pkg

//--- spi_reg_port.sv
// serial register port: mode 0, address byte then data byte
module spi_reg_port (
  input  wire logic                   ref_clk_i,
  input  wire logic                   sys_rst_i,
  input  wire logic                   spi_sel_n_i,
  input  wire logic                   spi_sclk_i,
  input  wire logic                   spi_mosi_i,
  input  wire logic [7:0]             rd_data_i,
  output logic                        spi_miso_o,
  output logic [5:0]                  rd_addr_o,
  output radio_ctrl_pkg::reg_wr_t     wr_o
);
  import radio_ctrl_pkg::*;

  // ==========================================================================
  // pin synchronisers
  logic [2:0] sclk_s, sel_s, mosi_s;
  logic       sclk_lvl_r, sclk_lvl_nxt, sel_n_lvl_r, sel_n_lvl_nxt;
  logic       rise, fall;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sclk_s <= 3'h0;
      sel_s  <= 3'h7;
      mosi_s <= 3'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], spi_sclk_i};
      sel_s  <= {sel_s[1:0], spi_sel_n_i};
      mosi_s <= {mosi_s[1:0], spi_mosi_i};
    end
  end

  // a level counts once stages two and three agree
  always_comb begin
    sclk_lvl_nxt  = (sclk_s[1] == sclk_s[2]) ? sclk_s[2] : sclk_lvl_r;
    sel_n_lvl_nxt = (sel_s[1] == sel_s[2]) ? sel_s[2] : sel_n_lvl_r;
    rise = !sel_n_lvl_r && sclk_lvl_nxt && !sclk_lvl_r;
    fall = !sel_n_lvl_r && !sclk_lvl_nxt && sclk_lvl_r;
  end

  // ==========================================================================
  // shifter
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sin_r, sin_nxt, sout_r, sout_nxt;
  logic       wr_mode_r, wr_mode_nxt, miso_nxt;
  logic [5:0] addr_nxt;
  reg_wr_t    wr_nxt;

  always_comb begin
    cnt_nxt     = cnt_r;
    sin_nxt     = sin_r;
    sout_nxt    = sout_r;
    wr_mode_nxt = wr_mode_r;
    miso_nxt    = spi_miso_o;
    addr_nxt    = rd_addr_o;
    wr_nxt      = '0;
    if (sel_n_lvl_r) begin
      cnt_nxt = 4'h0;
    end else if (rise) begin
      sin_nxt = {sin_r[6:0], mosi_s[2]};
      cnt_nxt = cnt_r + 4'h1;
      if (cnt_r == 4'h7) begin
        wr_mode_nxt = sin_r[SPI_WR_BIT - 1];
        addr_nxt    = {sin_r[4:0], mosi_s[2]};
      end
      if (cnt_r == 4'hf && wr_mode_r) begin
        wr_nxt.stb  = 1'b1;
        wr_nxt.addr = rd_addr_o;
        wr_nxt.data = {sin_r[6:0], mosi_s[2]};
      end
    end else if (fall) begin
      // miso moves only on a falling sclk edge
      if (cnt_r == 4'h8) begin
        sout_nxt = {rd_data_i[6:0], 1'b0};
        miso_nxt = rd_data_i[7];
      end else begin
        sout_nxt = {sout_r[6:0], 1'b0};
        miso_nxt = sout_r[7];
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sclk_lvl_r  <= 1'b0;
      sel_n_lvl_r <= 1'b1;
      cnt_r       <= 4'h0;
      sin_r       <= 8'h00;
      sout_r      <= 8'h00;
      wr_mode_r   <= 1'b0;
      spi_miso_o  <= 1'b0;
      rd_addr_o   <= 6'h00;
      wr_o        <= '0;
    end else begin
      sclk_lvl_r  <= sclk_lvl_nxt;
      sel_n_lvl_r <= sel_n_lvl_nxt;
      cnt_r       <= cnt_nxt;
      sin_r       <= sin_nxt;
      sout_r      <= sout_nxt;
      wr_mode_r   <= wr_mode_nxt;
      spi_miso_o  <= miso_nxt;
      rd_addr_o   <= addr_nxt;
      wr_o        <= wr_nxt;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_MISO_ON_FALL: assert property (
    $changed(spi_miso_o) |-> $past(fall))
    else $error("miso changed without a falling sclk");

endmodule : spi_reg_port

//--- auto_retry_tx_ctrl.sv
// auto-retry transmit controller with command and status register port
// ============================================================================
// Overview of operation
// - retry limit zero means no retransmission in an auto-retry transaction
// - a buffered frame is sent again by transmit-begin alone
// - listen command during active phase waits, runs right after it ends
// - frame arriving near ack wait end leaves result no-acknowledgment
// - acknowledgment wait lasts 46 symbols, not the standard 54
// - end irq comes late after retransmissions; host should retry itself
// - a channel check request may be dropped, done flag stays low
// - miso changes on the falling sclk edge
// - silicon version readable at address 0x1d
// - transaction result reported in a field of address 0x02
// - every received frame has its check sequence tested
module auto_retry_tx_ctrl #(
  parameter int unsigned ACK_WAIT_CYC_P = radio_ctrl_pkg::ACK_WAIT_CYC,
  parameter int unsigned IRQ_LATE_CYC_P = radio_ctrl_pkg::IRQ_LATE_CYC,
  parameter logic [7:0]  VERSION_ID     = radio_ctrl_pkg::VERSION_RST
) (
  input  wire logic                       ref_clk_i,
  input  wire logic                       sys_rst_i,
  input  wire logic                       spi_sel_n_i,
  input  wire logic                       spi_sclk_i,
  input  wire logic                       spi_mosi_i,
  input  wire radio_ctrl_pkg::radio_evt_t radio_i,
  output logic                            spi_miso_o,
  output logic                            tx_req_o,
  output logic                            rx_en_o,
  output logic                            cca_req_o,
  output logic                            channel_check_done_o,
  output logic                            frame_valid_o,
  output logic                            transfer_end_irq_o,
  output logic [4:0]                      transceiver_state_o
);
  import radio_ctrl_pkg::*;

  function automatic logic [4:0] vis_state(input ctrl_state_t s);
    case (s)
      S_OFF:       vis_state = VIS_OFF;
      S_RX:        vis_state = VIS_RX;
      S_SYNTH:     vis_state = VIS_SYNTH;
      S_ARET_IDLE: vis_state = VIS_IDLE;
      default:     vis_state = VIS_ACTIVE;
    endcase
  endfunction : vis_state

  // ==========================================================================
  // register port
  reg_wr_t    wr;
  logic [5:0] rd_addr;
  logic [7:0] rd_data;
  logic [3:0] retry_lim_r, retry_lim_nxt;
  logic [2:0] result_r, result_nxt;
  logic       cmd_stb, cca_cmd;
  transceiver_command_t cmd;

  spi_reg_port u_port (
    .ref_clk_i   (ref_clk_i),
    .sys_rst_i   (sys_rst_i),
    .spi_sel_n_i (spi_sel_n_i),
    .spi_sclk_i  (spi_sclk_i),
    .spi_mosi_i  (spi_mosi_i),
    .rd_data_i   (rd_data),
    .spi_miso_o  (spi_miso_o),
    .rd_addr_o   (rd_addr),
    .wr_o        (wr)
  );

  always_comb begin
    cmd_stb = wr.stb && wr.addr == ADDR_CMD;
    cmd     = transceiver_command_t'(wr.data[4:0]);
    cca_cmd = wr.stb && wr.addr == ADDR_CCA && wr.data[CCA_REQ_BIT];
    retry_lim_nxt = retry_lim_r;
    if (wr.stb && wr.addr == ADDR_RETRY) begin
      retry_lim_nxt = wr.data[RETRY_LSB +: 4];
    end
    case (rd_addr)
      ADDR_STATE:   rd_data = {3'h0, transceiver_state_o};
      ADDR_CMD:     rd_data = {result_r, 5'h00};
      ADDR_CCA:     rd_data = {channel_check_done_o, 7'h00};
      ADDR_VERSION: rd_data = VERSION_ID;
      ADDR_RETRY:   rd_data = {retry_lim_r, 4'h0};
      default:      rd_data = 8'h00;
    endcase
  end

  // ==========================================================================
  // transaction state machine
  ctrl_state_t state_r, state_nxt;
  logic [15:0] tmr_r, tmr_nxt;
  logic [3:0]  retry_cnt_r, retry_cnt_nxt;
  logic        pend_rx_r, pend_rx_nxt, tx_req_nxt, rx_en_nxt;
  logic        busy, ack_ok, miss, fin;

  always_comb begin
    state_nxt     = state_r;
    tmr_nxt       = tmr_r;
    retry_cnt_nxt = retry_cnt_r;
    pend_rx_nxt   = pend_rx_r;
    result_nxt    = result_r;
    tx_req_nxt    = 1'b0;
    miss          = 1'b0;
    fin           = 1'b0;
    busy          = state_r == S_TX || state_r == S_ACK || state_r == S_ACK_RX;
    ack_ok        = radio_i.rx_done && radio_i.fcs_ok && radio_i.is_ack;
    // held so the receiver is not switched on mid-transaction
    if (busy && cmd_stb && cmd == CMD_RX) begin
      pend_rx_nxt = 1'b1;
    end
    case (state_r)
      S_OFF, S_RX, S_SYNTH, S_ARET_IDLE: begin
        if (cmd_stb) begin
          case (cmd)
            CMD_OFF:   state_nxt = S_OFF;
            CMD_RX:    state_nxt = S_RX;
            CMD_SYNTH: state_nxt = S_SYNTH;
            CMD_ARET:  state_nxt = S_ARET_IDLE;
            CMD_TX_START: begin
              if (state_r == S_ARET_IDLE) begin
                state_nxt     = S_TX;
                tx_req_nxt    = 1'b1;
                retry_cnt_nxt = 4'h0;
              end
            end
            default: ;
          endcase
        end
      end
      S_TX: begin
        if (radio_i.tx_done) begin
          state_nxt = S_ACK;
          tmr_nxt   = 16'h0000;
        end
      end
      S_ACK: begin
        if (ack_ok) begin
          fin        = 1'b1;
          result_nxt = RES_SUCCESS;
        end else if (tmr_r == 16'(ACK_WAIT_CYC_P - 1)) begin
          // a frame already under way is taken in, but cannot count as ack
          if (radio_i.preamble) begin
            state_nxt = S_ACK_RX;
          end else begin
            miss = 1'b1;
          end
        end else begin
          tmr_nxt = tmr_r + 16'h0001;
        end
      end
      S_ACK_RX: begin
        if (radio_i.rx_done) begin
          miss = 1'b1;
        end
      end
      default: state_nxt = S_OFF;
    endcase
    if (miss) begin
      if (retry_cnt_r < retry_lim_r) begin
        state_nxt     = S_TX;
        tx_req_nxt    = 1'b1;
        retry_cnt_nxt = retry_cnt_r + 4'h1;
      end else begin
        fin        = 1'b1;
        result_nxt = RES_NO_ACK;
      end
    end
    if (fin) begin
      state_nxt   = pend_rx_nxt ? S_RX : S_ARET_IDLE;
      pend_rx_nxt = 1'b0;
    end
    rx_en_nxt = state_nxt == S_RX || state_nxt == S_ACK || state_nxt == S_ACK_RX;
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r             <= S_OFF;
      tmr_r               <= 16'h0000;
      retry_cnt_r         <= 4'h0;
      retry_lim_r         <= RETRY_RST;
      pend_rx_r           <= 1'b0;
      result_r            <= RES_SUCCESS;
      tx_req_o            <= 1'b0;
      rx_en_o             <= 1'b0;
      transceiver_state_o <= VIS_OFF;
    end else begin
      state_r             <= state_nxt;
      tmr_r               <= tmr_nxt;
      retry_cnt_r         <= retry_cnt_nxt;
      retry_lim_r         <= retry_lim_nxt;
      pend_rx_r           <= pend_rx_nxt;
      result_r            <= result_nxt;
      tx_req_o            <= tx_req_nxt;
      rx_en_o             <= rx_en_nxt;
      transceiver_state_o <= vis_state(state_nxt);
    end
  end

  // ==========================================================================
  // end-of-transfer interrupt
  logic [15:0] late_tmr_r, late_tmr_nxt;
  logic        late_act_r, late_act_nxt, irq_nxt;

  // after retransmissions the pulse trails the state change; software retry avoids it
  always_comb begin
    late_tmr_nxt = late_tmr_r;
    late_act_nxt = late_act_r;
    irq_nxt      = 1'b0;
    if (late_act_r) begin
      late_tmr_nxt = late_tmr_r + 16'h0001;
      if (late_tmr_r == 16'(IRQ_LATE_CYC_P - 1)) begin
        late_act_nxt = 1'b0;
        irq_nxt      = 1'b1;
      end
    end
    if (fin) begin
      if (retry_cnt_r != 4'h0) begin
        late_act_nxt = 1'b1;
        late_tmr_nxt = 16'h0000;
      end else begin
        irq_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      late_tmr_r         <= 16'h0000;
      late_act_r         <= 1'b0;
      transfer_end_irq_o <= 1'b0;
    end else begin
      late_tmr_r         <= late_tmr_nxt;
      late_act_r         <= late_act_nxt;
      transfer_end_irq_o <= irq_nxt;
    end
  end

  // ==========================================================================
  // channel check and frame acceptance
  logic cca_req_nxt, channel_check_done_nxt, fv_nxt;

  always_comb begin
    cca_req_nxt  = 1'b0;
    channel_check_done_nxt = channel_check_done_o;
    fv_nxt       = rx_en_o && radio_i.rx_done && radio_i.fcs_ok;
    if (cca_cmd && state_r == S_RX) begin
      // a request met by a busy engine is lost; done stays low
      channel_check_done_nxt = 1'b0;
      cca_req_nxt  = !radio_i.cca_busy;
    end
    if (radio_i.cca_valid) begin
      channel_check_done_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cca_req_o            <= 1'b0;
      channel_check_done_o <= 1'b1;
      frame_valid_o        <= 1'b0;
    end else begin
      cca_req_o            <= cca_req_nxt;
      channel_check_done_o <= channel_check_done_nxt;
      frame_valid_o        <= fv_nxt;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_NO_RETRY_AT_ZERO: assert property (
    (miss && retry_lim_r == 4'h0) |=> !tx_req_o && state_r != S_TX)
    else $error("retransmission with retry limit zero");

  AST_TX_BEGIN_ONLY: assert property (
    (state_r == S_ARET_IDLE && cmd_stb && cmd == CMD_TX_START)
      |=> tx_req_o && transceiver_state_o == VIS_ACTIVE)
    else $error("transmit-begin did not start the buffered frame");

  AST_RX_HELD: assert property (
    (busy && cmd_stb && cmd == CMD_RX && !fin) |=> !rx_en_o || state_r != S_RX)
    else $error("listen command ran during active phase");

  AST_RX_AFTER_BUSY: assert property (
    (fin && pend_rx_r) |=> state_r == S_RX && transceiver_state_o == VIS_RX)
    else $error("held listen command not run at end of active phase");

  AST_LATE_FRAME_NO_ACK: assert property (
    (state_r == S_ACK_RX && radio_i.rx_done && retry_cnt_r >= retry_lim_r)
      |=> result_r == RES_NO_ACK && (transfer_end_irq_o || late_act_r))
    else $error("late frame reported as success");

  AST_ACK_WAIT_LEN: assert property (
    (state_r == S_ACK) |-> tmr_r < 16'(ACK_WAIT_CYC_P))
    else $error("acknowledgment wait out of range");

  AST_LATE_IRQ: assert property (
    (fin && retry_cnt_r != 4'h0) |=> !transfer_end_irq_o ##0 late_act_r)
    else $error("irq after retransmissions not deferred");

  AST_CCA_DROPPED: assert property (
    (cca_cmd && state_r == S_RX && radio_i.cca_busy && !radio_i.cca_valid)
      |=> !cca_req_o && !channel_check_done_o)
    else $error("dropped channel check not reported as pending");

  AST_VERSION_READ: assert property (
    (rd_addr == ADDR_VERSION) |-> rd_data == VERSION_ID)
    else $error("version register reads wrong value");

  AST_RESULT_AT_END: assert property (
    (fin && ack_ok && state_r == S_ACK) |=> result_r == RES_SUCCESS ##1 1'b1)
    else $error("acknowledged transaction not reported as success");

  AST_FCS_CHECKED: assert property (
    frame_valid_o |-> $past(radio_i.fcs_ok) && $past(radio_i.rx_done))
    else $error("frame passed without a good check sequence");

  COV_SUCCESS: cover property (state_r == S_ACK && ack_ok);
  COV_RETRY: cover property (miss && tx_req_nxt);
  COV_HELD_RX: cover property (fin && pend_rx_r);
  COV_CCA_DROP: cover property (cca_cmd && state_r == S_RX && radio_i.cca_busy);

endmodule : auto_retry_tx_ctrl

//--- spi_host_model.sv
// host-side serial master that performs single register accesses
module spi_host_model (
  input  wire logic ref_clk_i,
  input  wire logic spi_miso_i,
  output logic      spi_sel_n_o,
  output logic      spi_sclk_o,
  output logic      spi_mosi_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // timing
  // half period well above the four clocks the pin synchronisers need
  localparam int HALF = 6;

  initial begin
    spi_sel_n_o = 1'b1;
    spi_sclk_o  = 1'b0;
    spi_mosi_o  = 1'b0;
  end

  task automatic half_wait();
    repeat (HALF) @(negedge ref_clk_i);
  endtask : half_wait

  // ==========================================================================
  // one access: address byte then data byte, msb first, mode 0
  task automatic xfer(input logic wr, input logic [5:0] addr, input logic [7:0] wdata,
                      output logic [7:0] rdata);
    logic [15:0] frame;
    frame = {wr, 1'b0, addr, wdata};
    rdata = 8'h00;
    @(negedge ref_clk_i);
    spi_sel_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi_o = frame[i];
      half_wait();
      // sampled just before the rise; the device moved it at the last fall
      if (i < 8) rdata = {rdata[6:0], spi_miso_i};
      spi_sclk_o = 1'b1;
      half_wait();
      spi_sclk_o = 1'b0;
    end
    half_wait();
    spi_sel_n_o = 1'b1;
    // released line no longer shows the last bit
    spi_mosi_o = ~spi_mosi_o;
    half_wait();
  endtask : xfer
endmodule : spi_host_model

//--- auto_retry_tx_control_tb_top.sv
// self-checking bench for the auto-retry transmit controller
module auto_retry_tx_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import radio_ctrl_pkg::*;

  // ==========================================================================
  // settings and signals
  // shortened waits keep the run short; expectations derive from these
  localparam int         ACK_W  = 20;
  localparam int         IRQ_L  = 4;
  localparam logic [6:0] EV_TXD = 7'h40;
  localparam logic [6:0] EV_ACK = 7'h1c;
  localparam logic [6:0] EV_FRM = 7'h18;
  localparam logic [6:0] EV_BAD = 7'h10;
  localparam logic [6:0] EV_CCA = 7'h02;

  logic       ref_clk, sys_rst, sel_n, sclk, mosi, miso, miso_q, sclk_q;
  logic       tx_req, rx_en, cca_req, done, fvalid, irq;
  logic [4:0] state;
  logic [7:0] d;
  radio_evt_t radio;
  int         miscompares = 0;
  int         check_count = 0;
  int         cyc = 0, txq = 0, ccq = 0, fvq = 0, n, t0;

  auto_retry_tx_ctrl #(.ACK_WAIT_CYC_P(ACK_W), .IRQ_LATE_CYC_P(IRQ_L)) auto_retry_tx_ctrl_i (
    .ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .spi_sel_n_i(sel_n), .spi_sclk_i(sclk),
    .spi_mosi_i(mosi), .radio_i(radio), .spi_miso_o(miso), .tx_req_o(tx_req),
    .rx_en_o(rx_en), .cca_req_o(cca_req), .channel_check_done_o(done),
    .frame_valid_o(fvalid), .transfer_end_irq_o(irq), .transceiver_state_o(state));

  spi_host_model spi_host_model_i (
    .ref_clk_i(ref_clk), .spi_miso_i(miso), .spi_sel_n_o(sel_n), .spi_sclk_o(sclk),
    .spi_mosi_o(mosi));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ==========================================================================
  // tasks
  task automatic tick(input int k);
    repeat (k) @(negedge ref_clk);
  endtask : tick

  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("counts: %0d checks, %0d mismatches", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  task automatic reg_wr(input logic [5:0] a, input logic [7:0] v);
    logic [7:0] unused;
    spi_host_model_i.xfer(1'b1, a, v, unused);
  endtask : reg_wr

  task automatic reg_rd(input logic [5:0] a);
    spi_host_model_i.xfer(1'b0, a, 8'h00, d);
  endtask : reg_rd

  // pulse fields last one clock; preamble and busy levels are kept
  task automatic evt(input logic [6:0] e);
    radio = radio_evt_t'(radio | e);
    tick(1);
    radio = radio_evt_t'(radio & 7'h21);
  endtask : evt

  task automatic wait_state(input logic [4:0] v);
    n = 0;
    while (state !== v && n < 2000) begin
      tick(1);
      n++;
    end
    check("state reached", {3'h0, state}, {3'h0, v});
  endtask : wait_state

  task automatic wait_irq();
    n = 0;
    while (irq !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
  endtask : wait_irq

  task automatic check_result(input logic [2:0] exp);
    reg_rd(ADDR_CMD);
    check("result", {5'h0, d[7:5]}, {5'h0, exp});
  endtask : check_result

  // ==========================================================================
  // monitor and hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (tx_req === 1'b1) txq++;
    if (cca_req === 1'b1) ccq++;
    if (fvalid === 1'b1) fvq++;
    if (sclk_q === 1'b1 && sclk === 1'b1) check("miso steady", {7'h0, miso}, {7'h0, miso_q});
    sclk_q <= sclk;
    miso_q <= miso;
    if (cyc == 30000) begin
      miscompares++;
      finish_test();
    end
  end

  // ==========================================================================
  // tests
  initial begin
    sys_rst = 1'b1;
    radio   = '0;
    tick(6);
    sys_rst = 1'b0;
    tick(6);
    check("state pin", {3'h0, state}, {3'h0, VIS_OFF});
    check("done pin", {7'h0, done}, 8'h01);
    reg_rd(ADDR_VERSION);
    check("version", d, VERSION_RST);
    reg_rd(ADDR_RETRY);
    check("retry reset", {4'h0, d[7:4]}, {4'h0, RETRY_RST});
    check_result(RES_SUCCESS);
    reg_rd(6'h3f);
    check("unmapped", d, 8'h00);
    $display("test reset: done");

    reg_wr(ADDR_RETRY, 8'h00);
    reg_wr(ADDR_CMD, {3'h0, CMD_ARET});
    wait_state(VIS_IDLE);
    t0 = txq;
    reg_wr(ADDR_CMD, {3'h0, CMD_TX_START});
    wait_state(VIS_ACTIVE);
    reg_wr(ADDR_CMD, {3'h0, CMD_RX});
    check("listen held", {3'h0, state}, {3'h0, VIS_ACTIVE});
    evt(EV_TXD);
    wait_state(VIS_RX);
    check("ack wait", n[7:0], 8'(ACK_W));
    check("rx after busy", {7'h0, rx_en}, 8'h01);
    wait_irq();
    check("irq delay", n[7:0], 8'h00);
    check("sends", 8'(txq - t0), 8'h01);
    check_result(RES_NO_ACK);
    $display("test no-ack with deferred listen: done");

    reg_wr(ADDR_CMD, {3'h0, CMD_ARET});
    wait_state(VIS_IDLE);
    t0 = txq;
    reg_wr(ADDR_CMD, {3'h0, CMD_TX_START});
    check("resend", 8'(txq - t0), 8'h01);
    evt(EV_TXD);
    tick(3);
    evt(EV_ACK);
    wait_state(VIS_IDLE);
    wait_irq();
    check("irq delay", n[7:0], 8'h00);
    check_result(RES_SUCCESS);
    $display("test resend with ack: done");

    t0 = txq;
    reg_wr(ADDR_CMD, {3'h0, CMD_TX_START});
    evt(EV_TXD);
    radio.preamble = 1'b1;
    tick(ACK_W + 4);
    check("late frame held", {3'h0, state}, {3'h0, VIS_ACTIVE});
    evt(EV_FRM);
    radio.preamble = 1'b0;
    wait_state(VIS_IDLE);
    check_result(RES_NO_ACK);
    check("sends", 8'(txq - t0), 8'h01);
    $display("test late frame: done");

    reg_wr(ADDR_RETRY, 8'h10);
    reg_rd(ADDR_RETRY);
    check("retry limit", {4'h0, d[7:4]}, 8'h01);
    t0 = txq;
    reg_wr(ADDR_CMD, {3'h0, CMD_TX_START});
    evt(EV_TXD);
    n = 0;
    while (txq - t0 < 2 && n < 200) begin
      tick(1);
      n++;
    end
    check("retransmit", 8'(txq - t0), 8'h02);
    evt(EV_TXD);
    wait_state(VIS_IDLE);
    check("ack wait", n[7:0], 8'(ACK_W));
    wait_irq();
    check("late irq", n[7:0], 8'(IRQ_L));
    reg_wr(ADDR_RETRY, 8'h00);
    $display("test retransmission: done");

    reg_wr(ADDR_CMD, {3'h0, CMD_RX});
    wait_state(VIS_RX);
    t0 = fvq;
    evt(EV_FRM);
    evt(EV_BAD);
    tick(2);
    check("good frames", 8'(fvq - t0), 8'h01);
    $display("test frame check: done");

    radio.cca_busy = 1'b1;
    t0 = ccq;
    reg_wr(ADDR_CCA, 8'h80);
    tick(20);
    radio.cca_busy = 1'b0;
    check("dropped check", 8'(ccq - t0), 8'h00);
    reg_rd(ADDR_CCA);
    check("done stuck", {7'h0, d[7]}, 8'h00);
    reg_wr(ADDR_CMD, {3'h0, CMD_SYNTH});
    check("synth state", {3'h0, state}, {3'h0, VIS_SYNTH});
    reg_wr(ADDR_CMD, {3'h0, CMD_RX});
    reg_wr(ADDR_CCA, 8'h80);
    check("check started", 8'(ccq - t0), 8'h01);
    evt(EV_CCA);
    tick(1);
    check("done pin", {7'h0, done}, 8'h01);
    reg_rd(ADDR_CCA);
    check("done bit", {7'h0, d[7]}, 8'h01);
    $display("test channel check recovery: done");

    reg_wr(ADDR_CMD, {3'h0, CMD_OFF});
    check("off state", {3'h0, state}, {3'h0, VIS_OFF});
    t0 = txq;
    reg_wr(ADDR_CMD, {3'h0, CMD_TX_START});
    check("begin refused", 8'(txq - t0), 8'h00);
    check("rx off", {7'h0, rx_en}, 8'h00);
    $display("test off state: done");
    finish_test();
  end
endmodule : auto_retry_tx_control_tb_top
